// ---- hdl/srsc_pkg.sv ----
// Constants, register map and carrier types for the reset source and bus clock control block
package srsc_pkg;

    // ------------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------------
    localparam int          ADDR_W         = 8;
    localparam int          DATA_W         = 32;
    localparam logic [7:0]  REG_CAUSE      = 8'h00;
    localparam logic [7:0]  REG_OPTION     = 8'h04;
    localparam logic [7:0]  REG_INT_STATUS = 8'h08;
    localparam logic [7:0]  REG_INT_CLEAR  = 8'h0c;
    localparam logic [7:0]  REG_INT_ENABLE = 8'h10;
    localparam logic [7:0]  REG_WDT_COUNT  = 8'h14;
    localparam logic [7:0]  REG_SRC_ENABLE = 8'h18;

    // ------------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------------
    localparam int          OPT_STOP_EN_BIT = 0;
    localparam logic [4:0]  CAUSE_RESET     = 5'h00;
    localparam logic [4:0]  INT_RESET       = 5'h00;
    localparam logic        OPT_RESET       = 1'b0;

    // ------------------------------------------------------------------
    // Watchdog, prescaler and reset timing
    // ------------------------------------------------------------------
    localparam logic [15:0] WDT_SERVICE_ADDR  = 16'hffff;
    localparam logic [7:0]  ERASED_BYTE       = 8'h00;
    localparam int          PRESCALE_CYCLES   = 4080;
    localparam int          PRE_W             = 12;
    localparam logic [11:0] PRE_KEEP_MASK     = 12'h01f;
    localparam int          WDT_W             = 6;
    localparam int          WDT_LIMIT_DEFAULT = 63;
    localparam int          INTERNAL_RESET_BUS_CYCLES   = 8;
    localparam int          INTERNAL_RESET_CLKS         = 2 * INTERNAL_RESET_BUS_CYCLES;
    localparam int          INTERNAL_RESET_W            = 5;

    // ------------------------------------------------------------------
    // Interrupt sources
    // ------------------------------------------------------------------
    localparam int          NUM_SRC = 24;
    localparam int          MAX_SRC = 128;
    localparam int          VEC_W   = 7;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic por;
        logic blank;
        logic bad_address_flag;
        logic bad_opcode_flag;
        logic wdt;
    } srsc_cause_type;

    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  data;
        logic        write;
        logic        op_fetch;
        logic        vec_fetch;
        logic        vec_low;
        logic        unmapped;
        logic        illegal_op;
        logic        stop_exec;
    } srsc_cpu_type;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } srsc_regbus_type;

endpackage

// ---- hdl/srsc_top.sv ----
// Reset source recording, watchdog, bus clock divider and interrupt request logic
// Overview of operation
// - Bus clock is the generator clock divided by two.
// - Watchdog overflow raises internal reset and sets the watchdog cause flag.
// - A write to the service address outside reset clears watchdog and prescaler bits 11..5.
// - Prescaler ticks the watchdog at most once every 4080 oscillator cycles.
// - Watchdog off only in monitor mode with interrupt pin at test voltage.
// - Illegal instruction sets the bad opcode flag and resets the chip.
// - Stop instruction with stop disabled acts as an illegal opcode reset.
// - Opcode fetch from unmapped space sets bad address flag and resets.
// - Data read from unmapped space causes no reset and no flag.
// - Erased reset vectors cause reset, then monitor mode is forced.
// - Interrupt control takes 24 sources, structure extendable to 128.
//
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/10ps
module srsc_top
    import srsc_pkg::*;
#(
    parameter int WDT_LIMIT = WDT_LIMIT_DEFAULT,
    parameter int PRESCALE  = PRESCALE_CYCLES
) (
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  wire logic                 poweron_reset_in_i,
    input  wire logic                 monitor_mode_i,
    input  wire logic                 irq_test_high_voltage_i,
    input  wire srsc_cpu_type         cpu_i,
    input  wire logic [NUM_SRC-1:0]   int_src_i,
    input  wire srsc_regbus_type      bus_i,
    output logic [DATA_W-1:0]         rd_data_o,
    output logic                      bus_clock_o,
    output logic                      internal_reset_o,
    output logic                      force_monitor_o,
    output logic                      int_req_o,
    output logic [VEC_W-1:0]          int_vec_o,
    output logic                      irq_o
);

    localparam logic [PRE_W-1:0]  PRE_LAST  = PRE_W'(PRESCALE - 1);
    localparam logic [WDT_W-1:0]  WDT_LAST  = WDT_W'(WDT_LIMIT);
    localparam logic [INTERNAL_RESET_W-1:0] INTERNAL_RESET_LAST = INTERNAL_RESET_W'(INTERNAL_RESET_CLKS - 1);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic                 bus_phase_ff,  nxt_bus_phase;
    logic [PRE_W-1:0]     pre_ff,        nxt_pre;
    logic [WDT_W-1:0]     wdt_ff,        nxt_wdt;
    srsc_cause_type       cause_ff,      nxt_cause;
    logic [4:0]           int_stat_ff,   nxt_int_stat;
    logic [4:0]           int_en_ff,     nxt_int_en;
    logic                 stop_en_ff,    nxt_stop_en;
    logic [NUM_SRC-1:0]   src_en_ff,     nxt_src_en;
    logic                 blank_hi_ff,   nxt_blank_hi;
    logic                 internal_reset_pend_ff,  nxt_internal_reset_pend;
    logic                 internal_reset_act_ff,   nxt_internal_reset_act;
    logic [INTERNAL_RESET_W-1:0]    internal_reset_cnt_ff,   nxt_internal_reset_cnt;
    logic                 monitor_ff,    nxt_monitor;
    logic                 int_req_ff,    nxt_int_req;
    logic [VEC_W-1:0]     int_vec_ff,    nxt_int_vec;
    logic [DATA_W-1:0]    rd_data_ff,    nxt_rd_data;
    logic [1:0]           por_sync_ff;
    logic [1:0]           hv_sync_ff;

    logic                 por_s;
    logic                 wdt_off;
    logic                 cpu_live;
    logic                 service;
    logic                 tick;
    logic                 ev_wdt;
    logic                 ev_bad_opcode_flag;
    logic                 ev_bad_address_flag;
    logic                 ev_blank;
    logic                 vec_zero;
    logic                 any_ev;
    logic [NUM_SRC-1:0]   pending;
    srsc_cause_type       ev_vec;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            por_sync_ff <= 2'h0;
            hv_sync_ff  <= 2'h0;
        end else begin
            por_sync_ff <= {por_sync_ff[0], poweron_reset_in_i};
            hv_sync_ff  <= {hv_sync_ff[0], irq_test_high_voltage_i};
        end
    end

    assign por_s   = por_sync_ff[1];
    assign wdt_off = monitor_mode_i & hv_sync_ff[1];

    // ------------------------------------------------------------------
    // Event detection
    // ------------------------------------------------------------------
    assign cpu_live = ~internal_reset_act_ff & ~por_s;
    assign service  = cpu_live & cpu_i.write & (cpu_i.addr == WDT_SERVICE_ADDR);
    assign tick     = (pre_ff == PRE_LAST);
    assign ev_wdt   = cpu_live & ~wdt_off & ~service & tick & (wdt_ff == WDT_LAST);
    assign ev_bad_opcode_flag  = cpu_live & (cpu_i.illegal_op | (cpu_i.stop_exec & ~stop_en_ff));
    assign ev_bad_address_flag  = cpu_live & cpu_i.op_fetch & cpu_i.unmapped;
    assign vec_zero = cpu_i.vec_fetch & (cpu_i.data == ERASED_BYTE);
    assign ev_blank = cpu_live & vec_zero & cpu_i.vec_low & blank_hi_ff;
    assign ev_vec   = '{por: 1'b0, blank: ev_blank, bad_address_flag: ev_bad_address_flag, bad_opcode_flag: ev_bad_opcode_flag, wdt: ev_wdt};
    assign any_ev   = ev_wdt | ev_bad_opcode_flag | ev_bad_address_flag | ev_blank;
    assign pending  = int_src_i & src_en_ff;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        nxt_bus_phase = ~bus_phase_ff;
        nxt_pre       = tick ? '0 : pre_ff + 1'b1;
        nxt_wdt       = wdt_ff;
        nxt_cause     = cause_ff;
        nxt_int_stat  = int_stat_ff;
        nxt_int_en    = int_en_ff;
        nxt_stop_en   = stop_en_ff;
        nxt_src_en    = src_en_ff;
        nxt_blank_hi  = blank_hi_ff;
        nxt_internal_reset_pend = internal_reset_pend_ff;
        nxt_internal_reset_act  = internal_reset_act_ff;
        nxt_internal_reset_cnt  = internal_reset_cnt_ff;
        nxt_monitor   = monitor_ff;
        nxt_rd_data   = '0;
        nxt_int_req   = |pending;
        nxt_int_vec   = '0;
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            if (pending[i]) begin
                nxt_int_vec = VEC_W'(i);
            end
        end

        // Watchdog and prescaler
        if (service) begin
            nxt_pre = nxt_pre & PRE_KEEP_MASK;
            nxt_wdt = '0;
        end else if (wdt_off || internal_reset_act_ff || por_s) begin
            nxt_wdt = '0;
        end else if (tick) begin
            nxt_wdt = (wdt_ff == WDT_LAST) ? '0 : wdt_ff + 1'b1;
        end

        // High vector byte seen as erased
        if (cpu_live && cpu_i.vec_fetch && !cpu_i.vec_low) begin
            nxt_blank_hi = vec_zero;
        end

        // Cause recording, survives internal reset
        if (por_s) begin
            nxt_cause = '{por: 1'b1, default: 1'b0};
        end else if (any_ev) begin
            nxt_cause = ev_vec;
        end

        // Register writes
        if (bus_i.wr) begin
            case (bus_i.addr)
                REG_OPTION: begin
                    nxt_stop_en = bus_i.wdata[OPT_STOP_EN_BIT];
                end
                REG_INT_CLEAR: begin
                    nxt_int_stat = int_stat_ff & ~bus_i.wdata[4:0];
                end
                REG_INT_ENABLE: begin
                    nxt_int_en = bus_i.wdata[4:0];
                end
                REG_SRC_ENABLE: begin
                    nxt_src_en = bus_i.wdata[NUM_SRC-1:0];
                end
                default: begin
                end
            endcase
        end
        // Set wins over a clear in the same cycle
        nxt_int_stat = nxt_int_stat | {ev_vec.blank, ev_vec.bad_address_flag, ev_vec.bad_opcode_flag, ev_vec.wdt, 1'b0};
        nxt_int_stat[0] = nxt_int_stat[0] | (por_s & ~cause_ff.por);

        // Register reads
        if (bus_i.rd) begin
            case (bus_i.addr)
                REG_CAUSE:      nxt_rd_data = {27'h0, cause_ff};
                REG_OPTION:     nxt_rd_data = {31'h0, stop_en_ff};
                REG_INT_STATUS: nxt_rd_data = {27'h0, int_stat_ff};
                REG_INT_ENABLE: nxt_rd_data = {27'h0, int_en_ff};
                REG_WDT_COUNT:  nxt_rd_data = {26'h0, wdt_ff};
                REG_SRC_ENABLE: nxt_rd_data = {8'h0, src_en_ff};
                default:        nxt_rd_data = '0;
            endcase
        end

        // Internal reset, started on a bus clock rising edge
        if (any_ev || por_s) begin
            nxt_internal_reset_pend = 1'b1;
        end
        if (internal_reset_act_ff) begin
            if (internal_reset_cnt_ff == '0) begin
                nxt_internal_reset_act = 1'b0;
                nxt_monitor  = monitor_ff | cause_ff.blank;
            end else begin
                nxt_internal_reset_cnt = internal_reset_cnt_ff - 1'b1;
            end
        end else if (internal_reset_pend_ff && !bus_phase_ff) begin
            nxt_internal_reset_act  = 1'b1;
            nxt_internal_reset_cnt  = INTERNAL_RESET_LAST;
            nxt_internal_reset_pend = 1'b0;
        end
        if (por_s) begin
            nxt_monitor = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bus_phase_ff <= 1'b0;
            pre_ff       <= '0;
            wdt_ff       <= '0;
            cause_ff     <= CAUSE_RESET;
            int_stat_ff  <= INT_RESET;
            int_en_ff    <= INT_RESET;
            stop_en_ff   <= OPT_RESET;
            src_en_ff    <= '0;
            blank_hi_ff  <= 1'b0;
            internal_reset_pend_ff <= 1'b0;
            internal_reset_act_ff  <= 1'b0;
            internal_reset_cnt_ff  <= '0;
            monitor_ff   <= 1'b0;
            int_req_ff   <= 1'b0;
            int_vec_ff   <= '0;
            rd_data_ff   <= '0;
        end else begin
            bus_phase_ff <= nxt_bus_phase;
            pre_ff       <= nxt_pre;
            wdt_ff       <= nxt_wdt;
            cause_ff     <= nxt_cause;
            int_stat_ff  <= nxt_int_stat;
            int_en_ff    <= nxt_int_en;
            stop_en_ff   <= nxt_stop_en;
            src_en_ff    <= nxt_src_en;
            blank_hi_ff  <= nxt_blank_hi;
            internal_reset_pend_ff <= nxt_internal_reset_pend;
            internal_reset_act_ff  <= nxt_internal_reset_act;
            internal_reset_cnt_ff  <= nxt_internal_reset_cnt;
            monitor_ff   <= nxt_monitor;
            int_req_ff   <= nxt_int_req;
            int_vec_ff   <= nxt_int_vec;
            rd_data_ff   <= nxt_rd_data;
        end
    end

    assign bus_clock_o      = bus_phase_ff;
    assign internal_reset_o = internal_reset_act_ff;
    assign force_monitor_o  = monitor_ff;
    assign int_req_o        = int_req_ff;
    assign int_vec_o        = int_vec_ff;
    assign rd_data_o        = rd_data_ff;
    assign irq_o            = |(int_stat_ff & int_en_ff);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    bus_clk_div_a: assert property (
        !$past(rst_i) |-> bus_clock_o != $past(bus_clock_o))
        else $error("bus clock did not toggle");

    wdt_cause_a: assert property (
        ev_wdt && !por_s
        |=> cause_ff.wdt && (internal_reset_pend_ff || internal_reset_o) ##[0:2] internal_reset_o)
        else $error("watchdog overflow did not record or reset");

    service_clear_a: assert property (
        service |=> wdt_ff == '0 && pre_ff[PRE_W-1:5] == '0)
        else $error("service write did not clear counters");

    tick_period_a: assert property (
        (pre_ff <= PRE_LAST) and (tick |=> pre_ff == '0))
        else $error("prescaler exceeded its period");

    wdt_off_a: assert property (
        wdt_off |=> wdt_ff == '0 && !cause_ff.wdt || $past(cause_ff.wdt))
        else $error("watchdog ran while disabled");

    bad_opcode_flag_flag_a: assert property (
        cpu_live && cpu_i.illegal_op |=> cause_ff.bad_opcode_flag ##[0:2] internal_reset_o)
        else $error("illegal opcode not recorded");

    stop_bad_opcode_flag_a: assert property (
        cpu_live && cpu_i.stop_exec && !cpu_i.illegal_op |-> ev_bad_opcode_flag == !stop_en_ff)
        else $error("stop handling wrong for stop enable");

    bad_address_flag_flag_a: assert property (
        cpu_live && cpu_i.op_fetch && cpu_i.unmapped
        |=> cause_ff.bad_address_flag && (internal_reset_pend_ff || internal_reset_o))
        else $error("illegal address not recorded");

    data_read_a: assert property (
        cpu_live && cpu_i.unmapped && !cpu_i.op_fetch && !cause_ff.bad_address_flag
        |=> !cause_ff.bad_address_flag)
        else $error("data read raised illegal address");

    blank_force_a: assert property (
        $fell(internal_reset_act_ff) && $past(cause_ff.blank) |-> force_monitor_o)
        else $error("blank vectors did not force monitor mode");

    int_req_a: assert property (
        int_req_o == $past(|pending)
        && (!int_req_o || |($past(pending) & (NUM_SRC'(1) << int_vec_o))))
        else $error("interrupt request or vector wrong");

    internal_reset_len_a: assert property (
        $rose(internal_reset_o) |-> bus_clock_o ##15 internal_reset_o ##1 !internal_reset_o)
        else $error("internal reset length or alignment wrong");

    irq_out_a: assert property (
        $rose(irq_o) |-> $past(|(nxt_int_stat & nxt_int_en)))
        else $error("interrupt output without enabled status");

endmodule

// ---- test/srsc_cpu_model.sv ----
// CPU core model issuing opcode, vector, data and service cycles on command
`timescale 1ns/10ps
module srsc_cpu_model
    import srsc_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       cmd_v_i,
    input  wire logic [2:0] cmd_i,
    input  wire logic [7:0] data_i,
    output srsc_cpu_type    cpu_o
);
    initial cpu_o = '0;
    always @(posedge clk_i) begin
        cpu_o <= '0;
        // Idle bus keeps changing instead of holding the last value
        cpu_o.addr <= ~cpu_o.addr;
        cpu_o.data <= ~cpu_o.data;
        if (cmd_v_i) begin
            cpu_o.data <= data_i;
            case (cmd_i)
                3'h0: begin
                    cpu_o.addr  <= WDT_SERVICE_ADDR;
                    cpu_o.write <= 1'b1;
                end
                3'h1: begin
                    cpu_o.op_fetch   <= 1'b1;
                    cpu_o.illegal_op <= 1'b1;
                end
                3'h2: begin
                    cpu_o.op_fetch  <= 1'b1;
                    cpu_o.stop_exec <= 1'b1;
                end
                3'h3, 3'h4: begin
                    cpu_o.addr     <= 16'h7000;
                    cpu_o.unmapped <= 1'b1;
                    cpu_o.op_fetch <= (cmd_i == 3'h3);
                end
                default: begin
                    cpu_o.addr      <= {15'h7fff, cmd_i[0]};
                    cpu_o.vec_fetch <= 1'b1;
                    cpu_o.vec_low   <= cmd_i[0];
                end
            endcase
        end
    end
endmodule

// ---- test/testbench.sv ----
// Self-checking bench for the reset source and bus clock control block
`timescale 1ns/10ps
module testbench
    import srsc_pkg::*;
;
    logic                 clk_i = 1'b0;
    logic                 rst_i = 1'b1;
    logic                 por_i = 1'b0;
    logic                 mon_i = 1'b1;
    logic                 hv_i  = 1'b1;
    logic                 cmd_v = 1'b0;
    logic [2:0]           cmd   = 3'h0;
    logic [7:0]           cdat  = 8'h00;
    logic [NUM_SRC-1:0]   src   = '0;
    srsc_regbus_type      bus   = '0;
    srsc_cpu_type         cpu_s;
    logic [DATA_W-1:0]    rdata;
    logic                 bclk;
    logic                 internal_reset;
    logic                 fmon;
    logic                 ireq;
    logic                 irq;
    logic [VEC_W-1:0]     ivec;
    logic [31:0]          v;
    int                   err_total = 0;
    int                   num_checks = 0;
    int                   rst_cnt = 0;
    int                   t;

    initial forever #4 clk_i = ~clk_i;

    srsc_cpu_model cpu_u (.clk_i(clk_i), .cmd_v_i(cmd_v), .cmd_i(cmd), .data_i(cdat),
        .cpu_o(cpu_s));

    srsc_top #(.WDT_LIMIT(2), .PRESCALE(8)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .poweron_reset_in_i(por_i), .monitor_mode_i(mon_i),
        .irq_test_high_voltage_i(hv_i), .cpu_i(cpu_s), .int_src_i(src), .bus_i(bus),
        .rd_data_o(rdata), .bus_clock_o(bclk), .internal_reset_o(internal_reset),
        .force_monitor_o(fmon), .int_req_o(ireq), .int_vec_o(ivec), .irq_o(irq));

    always @(posedge clk_i) if (internal_reset === 1'b1) rst_cnt++;

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge clk_i);
        bus.wr    <= 1'b0;
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_i);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge clk_i);
        bus.rd   <= 1'b0;
        #1;
        chk(nm, rdata, exp);
    endtask

    task automatic cpu(input logic [2:0] c, input logic [7:0] d);
        @(posedge clk_i);
        cmd_v <= 1'b1;
        cmd   <= c;
        cdat  <= d;
        @(posedge clk_i);
        cmd_v <= 1'b0;
    endtask

    // Waits for internal reset, returns cycles to rise, checks its length
    task automatic wait_rst(output int tr);
        int n;
        tr = 0;
        n = 0;
        while (internal_reset !== 1'b1 && tr < 40) begin
            cyc(1);
            tr++;
        end
        if (tr >= 40) begin
            chk("reset_rise", internal_reset, 32'h1);
            complete_run;
        end
        while (internal_reset === 1'b1 && n < 40) begin
            cyc(1);
            n++;
        end
        chk("reset_len", n, INTERNAL_RESET_CLKS);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        cyc(2);
        t = rst_cnt;
        rchk("cause", REG_CAUSE, 32'h0);
        rchk("option", REG_OPTION, 32'h0);
        rchk("status", REG_INT_STATUS, 32'h0);
        rchk("unmapped_reg", 8'h1c, 32'h0);
        v[0] = bclk;
        cyc(1);
        chk("bus_clock", bclk ^ v[0], 32'h1);
        cyc(1);
        chk("bus_clock", bclk ^ v[0], 32'h0);
        cyc(60);
        chk("wdt_disabled", rst_cnt - t, 32'h0);
        rchk("wdt_count", REG_WDT_COUNT, 32'h0);
        $display("test idle done");
        cpu(3'h1, 8'h00);
        wait_rst(t);
        rchk("cause_bad_opcode_flag", REG_CAUSE, 32'h2);
        rchk("status_bad_opcode_flag", REG_INT_STATUS, 32'h4);
        wr(REG_INT_ENABLE, 32'h4);
        rchk("int_enable", REG_INT_ENABLE, 32'h4);
        chk("irq_on", irq, 32'h1);
        wr(REG_INT_ENABLE, 32'h0);
        cyc(2);
        chk("irq_masked", irq, 32'h0);
        wr(REG_INT_ENABLE, 32'h4);
        wr(REG_INT_CLEAR, 32'h4);
        cyc(2);
        chk("irq_cleared", irq, 32'h0);
        rchk("status_cleared", REG_INT_STATUS, 32'h0);
        $display("test illegal opcode done");
        cpu(3'h2, 8'h00);
        wait_rst(t);
        rchk("cause_stop", REG_CAUSE, 32'h2);
        wr(REG_OPTION, 32'h1);
        rchk("option_set", REG_OPTION, 32'h1);
        t = rst_cnt;
        cpu(3'h2, 8'h00);
        cyc(30);
        chk("stop_allowed", rst_cnt - t, 32'h0);
        cpu(3'h4, 8'h00);
        cyc(30);
        chk("data_read_unmapped", rst_cnt - t, 32'h0);
        rchk("cause_kept", REG_CAUSE, 32'h2);
        cpu(3'h3, 8'h00);
        wait_rst(t);
        rchk("cause_bad_address_flag", REG_CAUSE, 32'h4);
        $display("test stop and address done");
        cpu(3'h6, ERASED_BYTE);
        cpu(3'h5, ERASED_BYTE);
        wait_rst(t);
        cyc(3);
        chk("force_monitor", fmon, 32'h1);
        rchk("cause_blank", REG_CAUSE, 32'h8);
        $display("test blank vector done");
        @(posedge clk_i);
        hv_i <= 1'b0;
        cyc(4);
        t = rst_cnt;
        repeat (12) begin
            cpu(3'h0, 8'h5a);
            cyc(6);
        end
        chk("wdt_serviced", rst_cnt - t, 32'h0);
        wait_rst(t);
        @(posedge clk_i);
        hv_i <= 1'b1;
        chk("wdt_window", (t >= 8) && (t <= 24), 32'h1);
        rchk("cause_wdt", REG_CAUSE, 32'h1);
        $display("test watchdog done");
        wr(REG_SRC_ENABLE, 32'h00ffffff);
        @(posedge clk_i);
        src <= 24'h800020;
        cyc(3);
        chk("int_req", ireq, 32'h1);
        chk("int_vec_low", ivec, 32'h5);
        @(posedge clk_i);
        src <= 24'h800000;
        cyc(3);
        chk("int_vec_top", ivec, 32'h17);
        wr(REG_SRC_ENABLE, 32'h007fffff);
        cyc(3);
        chk("int_req_masked", ireq, 32'h0);
        rchk("status_sticky", REG_INT_STATUS, 32'h1e);
        $display("test interrupt sources done");
        @(posedge clk_i);
        por_i <= 1'b1;
        @(posedge clk_i);
        por_i <= 1'b0;
        wait_rst(t);
        cyc(3);
        chk("force_monitor_por", fmon, 32'h0);
        rchk("cause_por", REG_CAUSE, 32'h10);
        rchk("status_por", REG_INT_STATUS, 32'h1f);
        $display("test power on done");
        complete_run;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        err_total++;
        complete_run;
    end
endmodule
